// file: bench/tdt_far_side.sv
// Far-side model of the timer: drives the external count pin.
// Assumes the bench clock; the pin moves just after rising edges.
`timescale 1ns/10ps
module tdt_far_side (
  // Clock.
  input wire logic i_sys_clk,
  // Pin toward the timer.
  output logic o_external_clock_pin
);
  // The pin starts low so the first edge of the first burst is rising.
  initial o_external_clock_pin = 1'b0;

  // Toggle the pin n times, each level held two cycles.
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_external_clock_pin <= ~o_external_clock_pin;
      @(posedge i_sys_clk);
    end
  endtask
endmodule // tdt_far_side

// file: bench/tdt_timer_tb_top.sv
// Self-checking bench for the 10-bit down timer, one task per scenario.
// Assumes the timer acks each bus cycle and that ticks are one-cycle pulses.
`timescale 1ns/10ps
module tdt_timer_tb_top;
  import tdt_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  tdt_wb_req_s wb = '0;
  logic itk = 1'b0;
  logic htk = 1'b0;
  logic ack, pwm, oe_n, irq, ipin;
  logic [31:0] dat, rd;
  int err_total = 0;
  int n_tests = 0;

  // A 40 ns clock.
  always #20 i_sys_clk = ~i_sys_clk;

  tdt_timer u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_wb(wb),
    .o_wb_ack(ack), .o_wb_dat(dat), .i_instr_tick(itk), .i_hso_tick(htk),
    .i_external_clock_pin(ipin), .o_pwm_output_pin(pwm), .o_pwm_oe_n(oe_n), .o_irq(irq));
  tdt_far_side u_far (.i_sys_clk(i_sys_clk), .o_external_clock_pin(ipin));

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle: the request stands until ack is seen high at a rising edge.
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge i_sys_clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
    for (i = 0; i < 20; i++) begin
      @(posedge i_sys_clk);
      if (ack === 1'b1) begin
        break;
      end
    end
    if (i == 20) begin
      err_total++;
      final_report();
    end
    rd = dat;
    wb <= '0;
    @(posedge i_sys_clk);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, exp, rd);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_sys_clk) itk <= 1'b1;
      @(posedge i_sys_clk) itk <= 1'b0;
    end
  endtask

  task automatic t_reset();
    rdchk("ctrl1", TDT_ADR_CTRL1, {24'h0, TDT_RST_CTRL1});
    rdchk("ctrl2", TDT_ADR_CTRL2, {24'h0, TDT_RST_CTRL2});
    rdchk("unmapped", 8'hfc, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_load();
    bus(1'b1, TDT_ADR_HIGH, 8'h40);
    bus(1'b1, TDT_ADR_COUNT, 8'h05);
    rdchk("count low", TDT_ADR_COUNT, 32'h05);
    rdchk("high bits", TDT_ADR_HIGH, 32'h50);
    bus(1'b1, TDT_ADR_CTRL1, 8'h01);
    bus(1'b1, TDT_ADR_HIGH, 8'h00);
    bus(1'b1, TDT_ADR_COUNT, 8'h02);
    rdchk("buffered reload", TDT_ADR_COUNT, 32'h05);
    bus(1'b1, TDT_ADR_CTRL1, 8'h00);
    $display("test load done");
  endtask

  task automatic t_once();
    bus(1'b1, TDT_ADR_HIGH, 8'h00);
    bus(1'b1, TDT_ADR_COUNT, 8'h03);
    bus(1'b1, TDT_ADR_INT, 8'h84);
    tick(2);
    rdchk("held count", TDT_ADR_COUNT, 32'h03);
    bus(1'b1, TDT_ADR_CTRL1, 8'h05);
    tick(3);
    @(negedge i_sys_clk);
    chk("irq early", 32'h0, {31'h0, irq});
    tick(1);
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("flag", TDT_ADR_INT, 32'hc4);
    rdchk("one-shot stop", TDT_ADR_CTRL1, 32'h04);
    bus(1'b1, TDT_ADR_INT, 8'h84);
    repeat (2) @(negedge i_sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, TDT_ADR_COUNT, 8'h00);
    bus(1'b1, TDT_ADR_CTRL1, 8'h01);
    tick(1);
    rdchk("wrap high", TDT_ADR_HIGH, 32'h30);
    bus(1'b1, TDT_ADR_CTRL1, 8'h00);
    $display("test one-shot done");
  endtask

  // Frame of four fast ticks; duty never exceeds the reload of three.
  task automatic t_pwm();
    int lows;
    bus(1'b1, TDT_ADR_COUNT, 8'h03);
    bus(1'b1, TDT_ADR_CTRL1, 8'hcb);
    htk <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, TDT_ADR_HIGH, 8'h00);
      bus(1'b1, TDT_ADR_DUTY, 8'(d));
      repeat (10) @(posedge i_sys_clk);
      lows = 0;
      repeat (8) begin
        @(negedge i_sys_clk);
        lows += int'(pwm === 1'b0);
      end
      chk("pwm low cycles", 32'(2 * d), 32'(lows));
    end
    chk("pin drive", 32'h0, {31'h0, oe_n});
    @(posedge i_sys_clk);
    htk <= 1'b0;
    bus(1'b1, TDT_ADR_CTRL1, 8'h00);
    $display("test pwm done");
  endtask

  // Seven toggles give four rising and three falling edges, so the edge choice shows.
  task automatic t_ext();
    logic [7:0] c2 [3] = '{8'h38, 8'h28, 8'h20};
    logic [7:0] ex [3] = '{8'h0d, 8'h0c, 8'h0e};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, TDT_ADR_CTRL2, c2[k]);
      bus(1'b1, TDT_ADR_COUNT, 8'h10);
      bus(1'b1, TDT_ADR_CTRL1, 8'h01);
      u_far.edges(7);
      bus(1'b1, TDT_ADR_CTRL1, 8'h00);
      u_far.edges(1);
      rdchk("pin count", TDT_ADR_COUNT, {24'h0, ex[k]});
    end
    $display("test external pin done");
  endtask

  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_load();
    t_once();
    t_pwm();
    t_ext();
    final_report();
  end
endmodule // tdt_timer_tb_top

// file: design/tdt_pkg.sv
// Package for the 10-bit down timer with PWM output.
// Assumes a classic Wishbone master with 32-bit data and byte-wide registers.
package tdt_pkg;
  // Register byte addresses.
  localparam logic [7:0] TDT_ADR_CTRL1 = 8'h00;
  localparam logic [7:0] TDT_ADR_CTRL2 = 8'h04;
  localparam logic [7:0] TDT_ADR_HIGH = 8'h08;
  localparam logic [7:0] TDT_ADR_COUNT = 8'h0c;
  localparam logic [7:0] TDT_ADR_DUTY = 8'h10;
  localparam logic [7:0] TDT_ADR_PSCV = 8'h14;
  localparam logic [7:0] TDT_ADR_INT = 8'h18;
  // Field positions in timer_control_one.
  localparam int TDT_C1_EN = 0;
  localparam int TDT_C1_RL = 1;
  localparam int TDT_C1_OS = 2;
  localparam int TDT_C1_HRC = 3;
  localparam int TDT_C1_POL = 6;
  localparam int TDT_C1_OEN = 7;
  // Field positions in timer_control_two.
  localparam int TDT_C2_CS = 5;
  localparam int TDT_C2_CE = 4;
  localparam int TDT_C2_PSN = 3;
  // Field positions in reload_and_duty_high_bits and interrupt_register_two.
  localparam int TDT_HI_RL = 6;
  localparam int TDT_HI_CNT = 4;
  localparam int TDT_HI_DU = 2;
  localparam int TDT_INT_GIE = 7;
  localparam int TDT_INT_IF = 6;
  localparam int TDT_INT_IE = 2;
  // Values after reset and fixed counts.
  localparam logic [7:0] TDT_RST_CTRL1 = 8'h00;
  localparam logic [7:0] TDT_RST_CTRL2 = 8'h08;
  localparam logic [9:0] TDT_CNT_FULL = 10'h3ff;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tdt_wb_req_s;

  // Whole state of the timer block.
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [1:0] rl_hi;
    logic [1:0] du_hi;
    logic [9:0] reload;
    logic [9:0] duty_buf;
    logic [9:0] duty_act;
    logic [9:0] cnt;
    logic [7:0] ps;
    logic ext_q;
    logic flag;
    logic ie;
    logic global_interrupt_enable;
    logic pwm;
    logic oe_n;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } tdt_state_s;
endpackage

// file: design/tdt_timer.sv
// 10-bit down-counting timer with prescaler, auto-reload and PWM output.
// Assumes a classic Wishbone master and pins synchronous to i_sys_clk.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module tdt_timer
  import tdt_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Wishbone slave.
  input tdt_pkg::tdt_wb_req_s i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Count sources, both synchronous one-cycle ticks, and the pin.
  input wire logic i_instr_tick,
  input wire logic i_hso_tick,
  input wire logic i_external_clock_pin,
  // PWM pin and interrupt request.
  output logic o_pwm_output_pin,
  output logic o_pwm_oe_n,
  output logic o_irq
);
  import tdt_pkg::*;

  tdt_state_s st;
  tdt_state_s next_st;
  logic src_tick;
  logic tick;
  logic uf;
  logic wr;
  logic wr_low;
  logic [7:0] mask;
  logic [7:0] wdat;

  // Writes land on the edge where ack is high, so data is held by the master then.
  assign wr = i_wb.cyc & i_wb.stb & i_wb.we & st.ack & i_wb.sel[0];
  assign wdat = i_wb.dat[7:0];
  assign wr_low = wr && i_wb.adr == TDT_ADR_COUNT;

  // Source choice: the pin is sampled once per clock, so its edges need no sync.
  always_comb begin
    if (st.ctrl1[TDT_C1_HRC]) begin
      src_tick = i_hso_tick;
    end else if (st.ctrl2[TDT_C2_CS]) begin
      if (st.ctrl2[TDT_C2_CE]) begin
        src_tick = st.ext_q & ~i_external_clock_pin;
      end else begin
        src_tick = ~st.ext_q & i_external_clock_pin;
      end
    end else begin
      src_tick = i_instr_tick;
    end
  end

  // Prescaler passes one tick in every two to the power of sel plus one.
  assign mask = 8'((8'h02 << st.ctrl2[2:0]) - 8'h01);
  assign tick = st.ctrl2[TDT_C2_PSN] ? src_tick : (src_tick && (st.ps & mask) == mask);
  assign uf = tick && st.ctrl1[TDT_C1_EN] && st.cnt == 10'h000;

  // All next-state logic of the block.
  always_comb begin
    next_st = st;
    next_st.ext_q = i_external_clock_pin;
    // Prescaler advances only while inserted, and is cleared when off.
    if (st.ctrl2[TDT_C2_PSN]) begin
      next_st.ps = 8'h00;
    end else if (src_tick) begin
      next_st.ps = st.ps + 8'h01;
    end
    // Counting, underflow and reload.
    if (tick && st.ctrl1[TDT_C1_EN]) begin
      if (st.cnt == 10'h000) begin
        next_st.duty_act = st.duty_buf;
        if (st.ctrl1[TDT_C1_OS]) begin
          next_st.ctrl1[TDT_C1_EN] = 1'b0;
        end else if (st.ctrl1[TDT_C1_RL]) begin
          next_st.cnt = st.reload;
        end else begin
          next_st.cnt = TDT_CNT_FULL;
        end
      end else begin
        next_st.cnt = st.cnt - 10'h001;
      end
    end
    // Register writes.
    if (wr) begin
      unique case (i_wb.adr)
        TDT_ADR_CTRL1: next_st.ctrl1 = wdat;
        TDT_ADR_CTRL2: begin
          next_st.ctrl2 = wdat;
          next_st.ps = 8'h00;
        end
        TDT_ADR_HIGH: begin
          next_st.rl_hi = wdat[TDT_HI_RL+:2];
          next_st.du_hi = wdat[TDT_HI_DU+:2];
        end
        TDT_ADR_COUNT: begin
          next_st.reload = {st.rl_hi, wdat};
          if (!st.ctrl1[TDT_C1_EN]) begin
            next_st.cnt = {st.rl_hi, wdat};
          end
        end
        TDT_ADR_DUTY: next_st.duty_buf = {st.du_hi, wdat};
        TDT_ADR_INT: begin
          next_st.global_interrupt_enable = wdat[TDT_INT_GIE];
          next_st.ie = wdat[TDT_INT_IE];
          if (!wdat[TDT_INT_IF]) begin
            next_st.flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Underflow sets the flag after any clear, so a same-cycle event survives.
    if (uf) begin
      next_st.flag = 1'b1;
    end
    next_st.irq = st.flag & st.ie & st.global_interrupt_enable;
    // PWM: active while the down count is below the duty, giving duty clocks.
    next_st.pwm = (st.cnt < st.duty_act) ^ st.ctrl1[TDT_C1_POL];
    next_st.oe_n = ~st.ctrl1[TDT_C1_OEN];
    // Bus answer one cycle after the request; unmapped addresses read zero.
    next_st.ack = i_wb.cyc & i_wb.stb & ~st.ack;
    next_st.dat = 32'h0000_0000;
    if (i_wb.cyc && i_wb.stb && !st.ack) begin
      unique case (i_wb.adr)
        TDT_ADR_CTRL1: next_st.dat[7:0] = st.ctrl1;
        TDT_ADR_CTRL2: next_st.dat[7:0] = st.ctrl2;
        TDT_ADR_HIGH: next_st.dat[7:0] = {st.rl_hi, st.cnt[9:8], st.du_hi, 2'b00};
        TDT_ADR_COUNT: next_st.dat[7:0] = st.cnt[7:0];
        TDT_ADR_DUTY: next_st.dat[7:0] = st.duty_buf[7:0];
        TDT_ADR_PSCV: next_st.dat[7:0] = st.ps;
        TDT_ADR_INT: begin
          next_st.dat[TDT_INT_GIE] = st.global_interrupt_enable;
          next_st.dat[TDT_INT_IF] = st.flag;
          next_st.dat[TDT_INT_IE] = st.ie;
        end
        default: begin
        end
      endcase
    end
  end

  // State register; every output below comes straight from it.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
      st.ctrl1 <= TDT_RST_CTRL1;
      st.ctrl2 <= TDT_RST_CTRL2;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_wb_ack = st.ack;
  assign o_wb_dat = st.dat;
  assign o_pwm_output_pin = st.pwm;
  assign o_pwm_oe_n = st.oe_n;
  assign o_irq = st.irq;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // Counter steps down by one on each enabled tick above zero.
  property p_dec;
    tick && st.ctrl1[TDT_C1_EN] && st.cnt != 10'h000 && !wr_low |=> st.cnt == $past(st.cnt) - 10'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not decrement");

  // A disabled counter holds unless a low reload write loads it.
  property p_hold;
    !st.ctrl1[TDT_C1_EN] && !wr_low |=> $stable(st.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("disabled counter moved");

  // Low reload write while disabled loads staged high bits and byte.
  property p_load;
    wr_low && !st.ctrl1[TDT_C1_EN] |=> st.cnt == {$past(st.rl_hi), $past(wdat)};
  endproperty
  a_load: assert property (p_load) else $error("immediate load wrong");

  // Underflow raises the flag, then the request two cycles on when enabled.
  property p_flag;
    uf && st.ie && st.global_interrupt_enable && !wr |=> st.flag ##1 o_irq;
  endproperty
  a_flag: assert property (p_flag) else $error("flag or request missing");

  // Flag never drops without a write to the interrupt register.
  property p_sticky;
    st.flag && !(wr && i_wb.adr == TDT_ADR_INT) |=> st.flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

  // One-shot underflow stops the timer.
  property p_oneshot;
    uf && st.ctrl1[TDT_C1_OS] && !wr |=> !st.ctrl1[TDT_C1_EN];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");

  // Non-stop underflow without reload restarts from all ones.
  property p_full;
    uf && !st.ctrl1[TDT_C1_OS] && !st.ctrl1[TDT_C1_RL] && !wr |=> st.cnt == TDT_CNT_FULL;
  endproperty
  a_full: assert property (p_full) else $error("restart not from all ones");

  // Output enable follows the PWM enable bit one cycle later.
  property p_oe;
    ##1 o_pwm_oe_n == !$past(st.ctrl1[TDT_C1_OEN]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin direction wrong");

  // Zero duty keeps the pin at its inactive level.
  property p_duty0;
    st.duty_act == 10'h000 |=> o_pwm_output_pin == $past(st.ctrl1[TDT_C1_POL]);
  endproperty
  a_duty0: assert property (p_duty0) else $error("zero duty went active");

  // The checks below pin down the register staging, the prescaler and each count source.
  // They look at the state one edge after the event, since every effect is registered, except a_ps_div2, which checks the unregistered tick in the same cycle.
  // A failure here points at the next-state logic rather than at the bus timing.

  // A write to the high register stages both upper pairs.
  property p_wr_hi;
    wr && i_wb.adr == TDT_ADR_HIGH |=>
      st.rl_hi == $past(wdat[7:6]) && st.du_hi == $past(wdat[3:2]);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high bits not staged");

  // A low reload write joins the staged upper bits into the buffered reload.
  property p_reload_wr;
    wr_low |=> st.reload == {$past(st.rl_hi), $past(wdat)};
  endproperty
  a_reload_wr: assert property (p_reload_wr) else $error("reload not joined");

  // A low duty write joins the staged upper bits into the buffered duty.
  property p_duty_wr;
    wr && i_wb.adr == TDT_ADR_DUTY |=> st.duty_buf == {$past(st.du_hi), $past(wdat)};
  endproperty
  a_duty_wr: assert property (p_duty_wr) else $error("duty not buffered");

  // The buffered duty becomes active at an underflow.
  property p_duty_upd;
    uf |=> st.duty_act == $past(st.duty_buf);
  endproperty
  a_duty_upd: assert property (p_duty_upd) else $error("duty not moved at underflow");

  // Between underflows the active duty never changes, so a frame is never torn.
  property p_duty_keep;
    !uf |=> $stable(st.duty_act);
  endproperty
  a_duty_keep: assert property (p_duty_keep) else $error("active duty moved");

  // Non-stop underflow with reload restarts from the buffered reload.
  property p_reload_nxt;
    uf && !st.ctrl1[TDT_C1_OS] && st.ctrl1[TDT_C1_RL] && !wr |=> st.cnt == $past(st.reload);
  endproperty
  a_reload_nxt: assert property (p_reload_nxt) else $error("restart not from reload");

  // While running, a low reload write only fills the buffer.
  property p_buffered;
    wr_low && st.ctrl1[TDT_C1_EN] && !tick |=> $stable(st.cnt);
  endproperty
  a_buffered: assert property (p_buffered) else $error("running counter loaded");

  // A read of the count register answers with the live counter.
  property p_cnt_rd;
    i_wb.cyc && i_wb.stb && !i_wb.we && !st.ack && i_wb.adr == TDT_ADR_COUNT |=>
      o_wb_dat[7:0] == $past(st.cnt[7:0]);
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read wrong");

  // A read of the prescaler register answers with its live value.
  property p_ps_rd;
    i_wb.cyc && i_wb.stb && !i_wb.we && !st.ack && i_wb.adr == TDT_ADR_PSCV |=>
      o_wb_dat[7:0] == $past(st.ps);
  endproperty
  a_ps_rd: assert property (p_ps_rd) else $error("prescaler read wrong");

  // An inserted prescaler advances on every source tick.
  property p_ps_step;
    src_tick && !st.ctrl2[TDT_C2_PSN] && !(wr && i_wb.adr == TDT_ADR_CTRL2) |=>
      st.ps == $past(st.ps) + 8'h01;
  endproperty
  a_ps_step: assert property (p_ps_step) else $error("prescaler did not step");

  // Rewriting the second control register restarts the prescaler.
  property p_ps_clr;
    wr && i_wb.adr == TDT_ADR_CTRL2 |=> st.ps == 8'h00;
  endproperty
  a_ps_clr: assert property (p_ps_clr) else $error("prescaler not cleared");

  // At the smallest ratio every second source tick is swallowed.
  property p_ps_div2;
    !st.ctrl2[TDT_C2_PSN] && st.ctrl2[2:0] == 3'h0 && src_tick && !st.ps[0] |-> !tick;
  endproperty
  a_ps_div2: assert property (p_ps_div2) else $error("prescaler passed a tick");

  // High-speed select counts oscillator ticks.
  property p_hso;
    st.ctrl1[TDT_C1_HRC] && st.ctrl2[TDT_C2_PSN] && st.ctrl1[TDT_C1_EN] && i_hso_tick &&
      st.cnt != 10'h000 && !wr_low |=> st.cnt == $past(st.cnt) - 10'h001;
  endproperty
  a_hso: assert property (p_hso) else $error("oscillator tick not counted");

  // With both selects clear the instruction tick is counted.
  property p_instr;
    !st.ctrl1[TDT_C1_HRC] && !st.ctrl2[TDT_C2_CS] && st.ctrl2[TDT_C2_PSN] &&
      st.ctrl1[TDT_C1_EN] && i_instr_tick && st.cnt != 10'h000 && !wr_low |=>
      st.cnt == $past(st.cnt) - 10'h001;
  endproperty
  a_instr: assert property (p_instr) else $error("instruction tick not counted");

  // Falling pin edges count when the edge bit is one.
  property p_fall;
    !st.ctrl1[TDT_C1_HRC] && st.ctrl2[TDT_C2_CS] && st.ctrl2[TDT_C2_CE] &&
      st.ctrl2[TDT_C2_PSN] && st.ctrl1[TDT_C1_EN] && st.ext_q && !i_external_clock_pin &&
      st.cnt != 10'h000 && !wr_low |=> st.cnt == $past(st.cnt) - 10'h001;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge not counted");

  // Rising pin edges count when the edge bit is zero.
  property p_rise;
    !st.ctrl1[TDT_C1_HRC] && st.ctrl2[TDT_C2_CS] && !st.ctrl2[TDT_C2_CE] &&
      st.ctrl2[TDT_C2_PSN] && st.ctrl1[TDT_C1_EN] && !st.ext_q && i_external_clock_pin &&
      st.cnt != 10'h000 && !wr_low |=> st.cnt == $past(st.cnt) - 10'h001;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge not counted");

  // No request unless both enables are set.
  property p_irq_off;
    !(st.ie && st.global_interrupt_enable) |=> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request without enables");

  // Full duty keeps the pin active below the top count.
  property p_full_duty;
    st.duty_act == TDT_CNT_FULL && st.cnt != TDT_CNT_FULL |=>
      o_pwm_output_pin != $past(st.ctrl1[TDT_C1_POL]);
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty went inactive");
endmodule // tdt_timer
